/* hdl/lcd_host_regs.svh */
/*
  Constants of the parallel host port: APB register offsets, field positions,
  command fields, configuration register indices and their reset values.
  Assumes inclusion by bare name from the design module and the test bench.
*/
`ifndef LCD_HOST_REGS_SVH
`define LCD_HOST_REGS_SVH

// APB word offsets
`define CTRL_OFS 12'h000
`define STATUS_OFS 12'h004
`define ADDR_OFS 12'h008
`define COUNT_OFS 12'h00c
`define CTRL_RESET 32'h0000_0001
`define CTRL_EN_BIT 0
`define STATUS_ILLEGAL_BIT 0
`define STATUS_TGT_BIT 1
`define STATUS_PART_LSB 2
`define STATUS_MODE_LSB 4
`define STATUS_DEPTH_BIT 8
`define STATUS_ORDER_BIT 9

// Host command fields
`define CMD_TGT_BIT 7
`define CMD_START_BIT 6

// Configuration register indices
`define HSTART_HI_IDX 7'h00
`define HSTART_LO_IDX 7'h01
`define HEND_HI_IDX 7'h02
`define HEND_LO_IDX 7'h03
`define VSTART_HI_IDX 7'h04
`define VSTART_LO_IDX 7'h05
`define VEND_HI_IDX 7'h06
`define VEND_LO_IDX 7'h07
`define HRES_HI_IDX 7'h08
`define HRES_LO_IDX 7'h09
`define WSTART_2_IDX 7'h0a
`define WSTART_1_IDX 7'h0b
`define WSTART_0_IDX 7'h0c

// Configuration reset values that are not zero
`define HEND_HI_DEF 8'h01
`define HEND_LO_DEF 8'h3f
`define VEND_LO_DEF 8'hef
`define HRES_HI_DEF 8'h01
`define HRES_LO_DEF 8'h40

// Frame memory
`define MEM_DEPTH 153600
`define CFG_COUNT 128

`endif

/* hdl/lcd_host_pkg.sv */
/*
  Types of the parallel host port: bus style and width, access target,
  and the bundle of host pins carried through the synchroniser.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package lcd_host_pkg;

  typedef enum logic [1:0] {
    W18 = 2'b00,
    W16 = 2'b01,
    W9 = 2'b10,
    W8 = 2'b11
  } bus_width_t;

  typedef enum logic {
    STYLE80 = 1'b0,
    STYLE68 = 1'b1
  } bus_style_t;

  typedef enum logic {
    TGT_REG = 1'b0,
    TGT_MEM = 1'b1
  } target_t;

  typedef struct packed {
    logic cs_n;
    logic cdsel;
    logic wr_n;
    logic rd_n;
    logic [17:0] data;
  } host_pins_t;

  typedef struct packed {
    logic [1:0] style_width;
    logic [1:0] spare;
    logic depth;
    logic order;
  } mode_pins_t;

endpackage

/* hdl/lcd_host_port.sv */
/*
  Parallel host port of a TFT LCD controller: command decode, register and
  frame memory bursts, pixel part assembly and normalisation, APB status.
  Assumes host pins are asynchronous to pclk and each strobe phase spans
  at least three pclk cycles.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lcd_host_regs.svh"

module lcd_host_port
  import lcd_host_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] bus_mode_sel,
  input wire logic pixel_depth_sel,
  input wire logic part_order_sel,
  input wire logic host_cs_n,
  input wire logic cmd_data_sel,
  input wire logic host_wr_n,
  input wire logic host_rd_n,
  input wire logic [17:0] host_data_in,
  output logic [17:0] host_data_out,
  output logic host_data_oe
);

  host_pins_t pin1_r, pin2_r, prev_r;
  mode_pins_t mode1_r, mode2_r;
  logic [7:0] cfg_r [0:`CFG_COUNT-1];
  logic [17:0] mem_r [0:`MEM_DEPTH-1];
  logic [31:0] ctrl_r, prdata_r, pix_count_r;
  logic pready_r, pslverr_r, illegal_r;
  logic [17:0] dout_r, acc_r;
  logic oe_r;
  target_t tgt_r;
  logic [6:0] reg_addr_r;
  logic [7:0] cmd_r;
  logic [1:0] part_r;
  logic [15:0] x_r, y_r;
  logic [17:0] row_r;

  bus_style_t style;
  bus_width_t width;
  logic [1:0] nparts, li;
  logic illegal, rd_act, wr_done, rd_done, en;
  logic cmd_wr, data_wr, data_rd, last_part, commit;
  logic [15:0] hstart, hend, vstart, vend;
  logic [9:0] hres;
  logic [17:0] wstart, mem_addr, acc_nxt, pix_norm, rd_pix, rd_value;
  logic apb_acc, apb_hit;

  // Part placement within the assembled pixel
  function automatic logic [17:0] place(input logic [17:0] d, input bus_width_t w,
                                        input logic [1:0] idx);
    case (w)
      W8: place = {10'h000, d[7:0]} << {idx, 3'b000};
      W9: place = idx[0] ? {d[8:0], 9'h000} : {9'h000, d[8:0]};
      W16: place = idx[0] ? {d[1:0], 16'h0000} : {2'b00, d[15:0]};
      default: place = d;
    endcase
  endfunction

  // Part selection for reads, placed on the low lanes
  function automatic logic [17:0] extract(input logic [17:0] p, input bus_width_t w,
                                          input logic [1:0] idx);
    case (w)
      W8: extract = (p >> {idx, 3'b000}) & 18'h000ff;
      W9: extract = idx[0] ? {9'h000, p[17:9]} : {9'h000, p[8:0]};
      W16: extract = idx[0] ? {16'h0000, p[17:16]} : {2'b00, p[15:0]};
      default: extract = p;
    endcase
  endfunction

  function automatic logic [7:0] cfg_default(input logic [6:0] idx);
    case (idx)
      `HEND_HI_IDX: cfg_default = `HEND_HI_DEF;
      `HEND_LO_IDX: cfg_default = `HEND_LO_DEF;
      `VEND_LO_IDX: cfg_default = `VEND_LO_DEF;
      `HRES_HI_IDX: cfg_default = `HRES_HI_DEF;
      `HRES_LO_IDX: cfg_default = `HRES_LO_DEF;
      default: cfg_default = 8'h00;
    endcase
  endfunction

  // Two-stage synchronisers for every host pin, one clock throughout
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin1_r <= '{cs_n: 1'b1, cdsel: 1'b1, wr_n: 1'b1, rd_n: 1'b1, data: 18'h00000};
      pin2_r <= '{cs_n: 1'b1, cdsel: 1'b1, wr_n: 1'b1, rd_n: 1'b1, data: 18'h00000};
      prev_r <= '{cs_n: 1'b1, cdsel: 1'b1, wr_n: 1'b1, rd_n: 1'b1, data: 18'h00000};
      mode1_r <= '0;
      mode2_r <= '0;
    end else begin
      pin1_r <= '{cs_n: host_cs_n, cdsel: cmd_data_sel, wr_n: host_wr_n,
                  rd_n: host_rd_n, data: host_data_in};
      pin2_r <= pin1_r;
      prev_r <= pin2_r;
      mode1_r <= '{style_width: bus_mode_sel[1:0], spare: bus_mode_sel[3:2],
                   depth: pixel_depth_sel, order: part_order_sel};
      mode2_r <= mode1_r;
    end
  end

  // Mode decode: bit 2 chooses style, low bits the width
  always_comb begin
    style = bus_style_t'(mode2_r.spare[0]);
    width = bus_width_t'(mode2_r.style_width);
  end

  // Part count and the forbidden 565 combinations
  always_comb begin
    case (width)
      W8: nparts = mode2_r.depth ? 2'd3 : 2'd2;
      W9: nparts = 2'd2;
      W16: nparts = mode2_r.depth ? 2'd2 : 2'd1;
      default: nparts = 2'd1;
    endcase
    illegal = !mode2_r.depth && (width == W9 || width == W18);
  end

  assign li = mode2_r.order ? (nparts - 2'd1 - part_r) : part_r;

  // Strobe decode; both styles share command/data line and data lanes
  always_comb begin
    en = ctrl_r[`CTRL_EN_BIT];
    if (style == STYLE80) begin
      rd_act = !pin2_r.cs_n && !pin2_r.rd_n;
      wr_done = !prev_r.cs_n && !prev_r.wr_n && pin2_r.wr_n;
      rd_done = !prev_r.cs_n && !prev_r.rd_n && pin2_r.rd_n;
    end else begin
      // 68 style: write pin carries read/write, read pin carries enable
      rd_act = !pin2_r.cs_n && pin2_r.rd_n && pin2_r.wr_n;
      wr_done = !prev_r.cs_n && prev_r.rd_n && !pin2_r.rd_n && !prev_r.wr_n;
      rd_done = !prev_r.cs_n && prev_r.rd_n && !pin2_r.rd_n && prev_r.wr_n;
    end
    cmd_wr = en && wr_done && !prev_r.cdsel;
    data_wr = en && wr_done && prev_r.cdsel;
    data_rd = en && rd_done && prev_r.cdsel;
  end

  // Window and start address from the configuration bytes
  always_comb begin
    hstart = {cfg_r[`HSTART_HI_IDX], cfg_r[`HSTART_LO_IDX]};
    hend = {cfg_r[`HEND_HI_IDX], cfg_r[`HEND_LO_IDX]};
    vstart = {cfg_r[`VSTART_HI_IDX], cfg_r[`VSTART_LO_IDX]};
    vend = {cfg_r[`VEND_HI_IDX], cfg_r[`VEND_LO_IDX]};
    hres = {cfg_r[`HRES_HI_IDX][1:0], cfg_r[`HRES_LO_IDX]};
    wstart = {cfg_r[`WSTART_2_IDX][1:0], cfg_r[`WSTART_1_IDX], cfg_r[`WSTART_0_IDX]};
    mem_addr = row_r + {2'b00, x_r - hstart};
  end

  // Pixel assembly and normalisation to three 6-bit planes
  always_comb begin
    acc_nxt = acc_r | place(prev_r.data, width, li);
    if (mode2_r.depth)
      pix_norm = acc_nxt;
    else
      pix_norm = {acc_nxt[15:11], acc_nxt[15], acc_nxt[10:5], acc_nxt[4:0], acc_nxt[4]};
    last_part = (part_r == nparts - 2'd1);
    commit = data_wr && tgt_r == TGT_MEM && !illegal && last_part;
  end

  // Read value: command byte, current register or a part of the pixel
  always_comb begin
    if (mem_addr < 18'(`MEM_DEPTH))
      rd_pix = mem_r[mem_addr];
    else
      rd_pix = 18'h00000;
    if (!mode2_r.depth)
      rd_pix = {2'b00, rd_pix[17:13], rd_pix[11:6], rd_pix[5:1]};
    if (!pin2_r.cdsel)
      rd_value = {10'h000, cmd_r};
    else if (tgt_r == TGT_REG)
      rd_value = {10'h000, cfg_r[reg_addr_r]};
    else
      rd_value = extract(rd_pix, width, li);
  end

  // Command decode and target selection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tgt_r <= TGT_REG;
      cmd_r <= 8'h00;
    end else if (cmd_wr) begin
      cmd_r <= prev_r.data[7:0];
      tgt_r <= target_t'(prev_r.data[`CMD_TGT_BIT]);
    end
  end

  // Register address counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      reg_addr_r <= 7'h00;
    else if (cmd_wr && !prev_r.data[`CMD_TGT_BIT])
      reg_addr_r <= prev_r.data[6:0];
    else if ((data_wr || data_rd) && tgt_r == TGT_REG)
      reg_addr_r <= reg_addr_r + 7'h01;
  end

  // Configuration bytes written by host data bursts
  generate
    for (genvar i = 0; i < `CFG_COUNT; i++) begin : g_cfg
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
          cfg_r[i] <= cfg_default(7'(i));
        else if (data_wr && tgt_r == TGT_REG && reg_addr_r == 7'(i))
          cfg_r[i] <= prev_r.data[7:0];
      end
    end
  endgenerate

  // Part counter and assembly latch, cleared by any command
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      part_r <= 2'd0;
      acc_r <= 18'h00000;
    end else if (cmd_wr) begin
      part_r <= 2'd0;
      acc_r <= 18'h00000;
    end else if ((data_wr || data_rd) && tgt_r == TGT_MEM && !illegal) begin
      if (last_part) begin
        part_r <= 2'd0;
        acc_r <= 18'h00000;
      end else begin
        part_r <= part_r + 2'd1;
        acc_r <= data_wr ? acc_nxt : 18'h00000;
      end
    end
  end

  // Window walk: x across the line, then y, rows spaced by image width
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      x_r <= 16'h0000;
      y_r <= 16'h0000;
      row_r <= 18'h00000;
    end else if (cmd_wr && prev_r.data[`CMD_TGT_BIT] && prev_r.data[`CMD_START_BIT]) begin
      x_r <= hstart;
      y_r <= vstart;
      row_r <= wstart;
    end else if ((data_wr || data_rd) && tgt_r == TGT_MEM && !illegal && last_part) begin
      if (x_r == hend) begin
        x_r <= hstart;
        if (y_r == vend) begin
          y_r <= vstart;
          row_r <= wstart;
        end else begin
          y_r <= y_r + 16'h0001;
          row_r <= row_r + {8'h00, hres};
        end
      end else begin
        x_r <= x_r + 16'h0001;
      end
    end
  end

  // Frame memory; writes beyond the last pixel are dropped
  always_ff @(posedge pclk) begin
    if (commit && mem_addr < 18'(`MEM_DEPTH))
      mem_r[mem_addr] <= pix_norm;
  end

  // Host data lanes: driven only while a selected read strobe stands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      oe_r <= 1'b0;
      dout_r <= 18'h00000;
    end else begin
      oe_r <= en && rd_act;
      if (en && rd_act)
        dout_r <= rd_value;
    end
  end

  // Pixel counter and sticky illegal-mode flag; set wins over clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pix_count_r <= 32'h0000_0000;
      illegal_r <= 1'b0;
    end else begin
      if (commit)
        pix_count_r <= pix_count_r + 32'h0000_0001;
      if ((data_wr || data_rd) && tgt_r == TGT_MEM && illegal)
        illegal_r <= 1'b1;
      else if (apb_acc && pwrite && paddr == `STATUS_OFS && pwdata[`STATUS_ILLEGAL_BIT])
        illegal_r <= 1'b0;
    end
  end

  // APB slave: one wait state, unmapped offsets answer with an error
  assign apb_acc = psel && penable && !pready_r;
  assign apb_hit = paddr == `CTRL_OFS || paddr == `STATUS_OFS ||
                   paddr == `ADDR_OFS || paddr == `COUNT_OFS;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= 32'h0000_0000;
      ctrl_r <= `CTRL_RESET;
    end else begin
      pready_r <= apb_acc;
      pslverr_r <= apb_acc && !apb_hit;
      if (apb_acc && pwrite && paddr == `CTRL_OFS)
        ctrl_r <= {31'h0000_0000, pwdata[`CTRL_EN_BIT]};
      if (apb_acc && !pwrite) begin
        case (paddr)
          `CTRL_OFS: prdata_r <= ctrl_r;
          `STATUS_OFS: prdata_r <= {22'h000000, mode2_r.order, mode2_r.depth,
                                    mode2_r.spare, mode2_r.style_width,
                                    part_r, tgt_r, illegal_r};
          `ADDR_OFS: prdata_r <= {14'h0000, mem_addr};
          `COUNT_OFS: prdata_r <= pix_count_r;
          default: prdata_r <= 32'h0000_0000;
        endcase
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign host_data_out = dout_r;
  assign host_data_oe = oe_r;

  // Checks
  lane_drive_only_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    host_data_oe |-> $past(!pin2_r.cs_n) && $past(en))
    else $error("data lanes driven outside a selected read");

  reg_cmd_load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cmd_wr && !prev_r.data[7] |=> tgt_r == TGT_REG && reg_addr_r == $past(prev_r.data[6:0]))
    else $error("register command did not load address");

  mem_cmd_sel_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cmd_wr && prev_r.data[7] |=> tgt_r == TGT_MEM)
    else $error("memory command did not select memory");

  reg_burst_step_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    data_wr && tgt_r == TGT_REG |=> reg_addr_r == $past(reg_addr_r) + 7'h01 &&
      cfg_r[$past(reg_addr_r)] == $past(prev_r.data[7:0]))
    else $error("register burst write did not store and advance");

  reg_read_step_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    data_rd && tgt_r == TGT_REG |=> reg_addr_r == $past(reg_addr_r) + 7'h01)
    else $error("register read did not advance");

  start_addr_load_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    cmd_wr && prev_r.data[7] && prev_r.data[6] |=> mem_addr == $past(wstart))
    else $error("memory start did not load write start address");

  part_bound_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    part_r < nparts || $changed(mode2_r))
    else $error("part counter beyond parts per pixel");

  illegal_drop_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    data_wr && tgt_r == TGT_MEM && illegal |=> $stable(pix_count_r) ##1 illegal_r)
    else $error("forbidden mode data not dropped and flagged");

  pixel_commit_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    commit |=> pix_count_r == $past(pix_count_r) + 32'h0000_0001 && part_r == 2'd0)
    else $error("pixel commit did not count or reset parts");

  apb_pulse_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pready |=> pready ##1 !pready)
    else $error("apb ready not a single cycle answer");

endmodule // lcd_host_port
`default_nettype wire

/* testbench/host_cpu_model.sv */
/*
  Behavioural external microprocessor on the parallel host port, both styles.
  Assumes the bench supplies pclk and calls idle and xfer by hierarchy.
*/
`timescale 1ns/1ps
`default_nettype none

module host_cpu_model (
  input wire logic pclk,
  input wire logic [17:0] host_data_out,
  input wire logic host_data_oe,
  output logic host_cs_n,
  output logic cmd_data_sel,
  output logic host_wr_n,
  output logic host_rd_n,
  output logic [17:0] host_data_in
);
  localparam int PHASE = 6;
  logic style68 = 1'b0;

  initial begin
    host_cs_n = 1'b1;
    cmd_data_sel = 1'b1;
    host_wr_n = 1'b1;
    host_rd_n = 1'b1;
    host_data_in = 18'h0;
  end

  // Idle strobes of the chosen style
  task automatic idle(input logic s68);
    style68 = s68;
    @(posedge pclk);
    host_wr_n <= 1'b1;
    host_rd_n <= !s68;
  endtask

  // One transfer; a read leaves the lanes to the device
  task automatic xfer(input logic rd, input logic cd, input logic [17:0] d,
                      output logic [17:0] q, output logic oe);
    @(posedge pclk);
    host_cs_n <= 1'b0;
    cmd_data_sel <= cd;
    host_data_in <= rd ? ~host_data_in : d;
    if (style68)
      host_wr_n <= rd;
    repeat (PHASE) @(posedge pclk);
    if (style68)
      host_rd_n <= 1'b1;
    else if (rd)
      host_rd_n <= 1'b0;
    else
      host_wr_n <= 1'b0;
    repeat (PHASE) @(posedge pclk);
    q = host_data_out;
    oe = host_data_oe;
    host_rd_n <= !style68;
    host_wr_n <= style68 ? rd : 1'b1;
    // Data and select held past the closing edge
    repeat (PHASE) @(posedge pclk);
    host_cs_n <= 1'b1;
    host_data_in <= ~d;
    host_wr_n <= 1'b1;
  endtask
endmodule // host_cpu_model
`default_nettype wire

/* testbench/lcd_mpu_host_port_test.sv */
/*
  Self-checking bench of the parallel host port: mode table of pixels,
  register bursts in every bus mode, window walk, status and bus errors.
  Assumes the design package, header and host model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
`include "lcd_host_regs.svh"

module lcd_mpu_host_port_test;
  import lcd_host_pkg::*;

  typedef struct {
    logic [3:0] mode;
    logic depth;
    logic order;
    logic [17:0] px;
  } row_t;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ard;
  logic [3:0] bus_mode_sel;
  logic pixel_depth_sel, part_order_sel, host_cs_n, cmd_data_sel;
  logic host_wr_n, host_rd_n, host_data_oe, hoe, aerr;
  logic [17:0] host_data_in, host_data_out, hq;
  int num_errors = 0;
  int checked = 0;
  logic [7:0] defs[13] = '{8'h00, 8'h00, 8'h01, 8'h3f, 8'h00, 8'h00, 8'h00,
                           8'hef, 8'h01, 8'h40, 8'h00, 8'h00, 8'h00};
  row_t rows[12] = '{
    '{4'h1, 1'b0, 1'b0, 18'h01234}, '{4'h5, 1'b0, 1'b0, 18'h0f81f},
    '{4'h3, 1'b0, 1'b0, 18'h05a3c}, '{4'h7, 1'b0, 1'b1, 18'h0c3a5},
    '{4'h3, 1'b1, 1'b0, 18'h2abcd}, '{4'h7, 1'b1, 1'b1, 18'h1c3e7},
    '{4'h2, 1'b1, 1'b0, 18'h35a96}, '{4'h6, 1'b1, 1'b1, 18'h0f0f1},
    '{4'h1, 1'b1, 1'b0, 18'h3e1c2}, '{4'h5, 1'b1, 1'b1, 18'h24681},
    '{4'h0, 1'b1, 1'b0, 18'h13579}, '{4'h4, 1'b1, 1'b1, 18'h0bdf8}};

  lcd_host_port lcd_host_port_inst (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .bus_mode_sel(bus_mode_sel), .pixel_depth_sel(pixel_depth_sel),
    .part_order_sel(part_order_sel), .host_cs_n(host_cs_n),
    .cmd_data_sel(cmd_data_sel), .host_wr_n(host_wr_n), .host_rd_n(host_rd_n),
    .host_data_in(host_data_in), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe));

  host_cpu_model host_cpu_model_inst (.pclk(pclk), .host_data_out(host_data_out),
    .host_data_oe(host_data_oe), .host_cs_n(host_cs_n),
    .cmd_data_sel(cmd_data_sel), .host_wr_n(host_wr_n), .host_rd_n(host_rd_n),
    .host_data_in(host_data_in));

  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (pready !== 1'b1)
      num_errors++;
    ard = prdata;
    aerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic host(input logic rd, input logic cd, input logic [17:0] d);
    host_cpu_model_inst.xfer(rd, cd, d, hq, hoe);
    if (rd) begin
      check(32'(hoe), 32'h1);
      check(32'(host_data_oe), 32'h0);
    end
  endtask

  task automatic set_mode(input logic [3:0] m, input logic dp, input logic od);
    @(posedge pclk);
    bus_mode_sel <= m;
    pixel_depth_sel <= dp;
    part_order_sel <= od;
    host_cpu_model_inst.idle(m[2]);
    repeat (6) @(posedge pclk);
  endtask

  function automatic logic [17:0] to666(input logic [15:0] p);
    return {p[15:11], p[15], p[10:5], p[4:0], p[4]};
  endfunction

  // Split one pixel into bus parts, junk on unused upper lanes
  task automatic send_px(input row_t r);
    logic [17:0] lp[3];
    logic [17:0] mask;
    int n;
    lp = '{r.px, 18'(r.px[17:16]), 18'h0};
    n = 1;
    mask = 18'h3ffff;
    case (r.mode[1:0])
      2'b01: begin
        mask = 18'h0ffff;
        lp[0] = 18'(r.px[15:0]);
        n = r.depth ? 2 : 1;
      end
      2'b10: begin
        mask = 18'h001ff;
        lp[0] = 18'(r.px[8:0]);
        lp[1] = 18'(r.px[17:9]);
        n = 2;
      end
      2'b11: begin
        mask = 18'h000ff;
        lp = '{18'(r.px[7:0]), 18'(r.px[15:8]), 18'(r.px[17:16])};
        n = r.depth ? 3 : 2;
      end
      default: ;
    endcase
    for (int i = 0; i < n; i++)
      host(1'b0, 1'b1, lp[r.order ? n - 1 - i : i] | (18'h2a5a5 & ~mask));
  endtask

  initial begin
    repeat (20000) @(posedge pclk);
    num_errors++;
    close_out();
  end

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h0;
    pwdata = 32'h0;
    bus_mode_sel = 4'h0;
    pixel_depth_sel = 1'b0;
    part_order_sel = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    apb(1'b0, `CTRL_OFS, 32'h0);
    check(ard, `CTRL_RESET);
    set_mode(4'h0, 1'b1, 1'b0);
    host(1'b0, 1'b0, 18'h0);
    for (int i = 0; i < 13; i++) begin
      host(1'b1, 1'b1, 18'h0);
      check(32'(hq[7:0]), 32'(defs[i]));
    end
    $display("reset values done");
    for (int m = 0; m < 8; m++) begin
      set_mode(4'(m), 1'b1, 1'b0);
      host(1'b0, 1'b0, 18'(8'h30 + m * 4));
      for (int k = 0; k < 3; k++)
        host(1'b0, 1'b1, 18'h3fc00 | 18'(m * 16 + k));
      host(1'b0, 1'b0, 18'(8'h30 + m * 4));
      for (int k = 0; k < 3; k++) begin
        host(1'b1, 1'b1, 18'h0);
        check(32'(hq[7:0]), 32'(m * 16 + k));
      end
    end
    // Register address wraps from the top
    host(1'b0, 1'b0, 18'h07f);
    host(1'b0, 1'b1, 18'h05c);
    host(1'b0, 1'b1, 18'h000);
    host(1'b0, 1'b0, 18'h07f);
    host(1'b1, 1'b1, 18'h0);
    check(32'(hq[7:0]), 32'h5c);
    host(1'b1, 1'b1, 18'h0);
    check(32'(hq[7:0]), 32'h00);
    $display("register bursts done");
    for (int i = 0; i < 12; i++) begin
      set_mode(rows[i].mode, rows[i].depth, rows[i].order);
      host(1'b0, 1'b0, 18'h0c0);
      send_px(rows[i]);
      set_mode(4'h0, 1'b1, 1'b0);
      host(1'b0, 1'b0, 18'h0c0);
      host(1'b1, 1'b1, 18'h0);
      check(32'(hq), 32'(rows[i].depth ? rows[i].px : to666(rows[i].px[15:0])));
      apb(1'b0, `COUNT_OFS, 32'h0);
      check(ard, 32'(i + 1));
    end
    $display("pixel table done");
    // Two-column window: third pixel lands on the next row
    host(1'b0, 1'b0, 18'h002);
    host(1'b0, 1'b1, 18'h000);
    host(1'b0, 1'b1, 18'h001);
    host(1'b0, 1'b0, 18'h0c0);
    for (int k = 0; k < 3; k++)
      host(1'b0, 1'b1, 18'(32'h11111 * (k + 1)));
    apb(1'b0, `ADDR_OFS, 32'h0);
    check(ard, 32'h141);
    host(1'b0, 1'b0, 18'h0c0);
    for (int k = 0; k < 3; k++) begin
      host(1'b1, 1'b1, 18'h0);
      check(32'(hq), 32'h11111 * (k + 1));
    end
    $display("window walk done");
    set_mode(4'h6, 1'b1, 1'b1);
    apb(1'b0, `STATUS_OFS, 32'h0);
    check(32'(ard[9:4]), 32'h36);
    set_mode(4'h0, 1'b0, 1'b0);
    host(1'b0, 1'b0, 18'h0c0);
    host(1'b0, 1'b1, 18'h01234);
    apb(1'b0, `STATUS_OFS, 32'h0);
    check(32'(ard[1:0]), 32'h3);
    apb(1'b0, `COUNT_OFS, 32'h0);
    check(ard, 32'd15);
    apb(1'b1, `STATUS_OFS, 32'h1);
    apb(1'b0, `STATUS_OFS, 32'h0);
    check(32'(ard[0]), 32'h0);
    // Command read returns the last command byte
    host(1'b1, 1'b0, 18'h0);
    check(32'(hq[7:0]), 32'h0c0);
    // Disabled port ignores a command write
    apb(1'b1, `CTRL_OFS, 32'h0);
    host(1'b0, 1'b0, 18'h005);
    apb(1'b1, `CTRL_OFS, 32'h1);
    host(1'b1, 1'b0, 18'h0);
    check(32'(hq[7:0]), 32'h0c0);
    apb(1'b0, 12'h010, 32'h0);
    check({ard[30:0], aerr}, 32'h1);
    $display("status and errors done");
    close_out();
  end
endmodule // lcd_mpu_host_port_test
`default_nettype wire
